//--- hw/spc_pkg.sv
// package: constants and state type for the set point clamp and ramp block
package spc_pkg;
   localparam int          CLK_HZ       = 10_000_000;
   localparam int          SEC_S        = 1;
   localparam int          SEC_CYCLES   = CLK_HZ * SEC_S;
   localparam int          SEC_CW       = 24;
   localparam int          UNIT_CW      = 12;
   localparam logic [11:0] SEC_PER_MIN  = 12'h003C;
   localparam logic [11:0] SEC_PER_HOUR = 12'h0E10;
   localparam int          MSP_DEPTH    = 8;
   localparam int          MSP_AW       = 3;
   // register byte addresses
   localparam logic [7:0]  ADR_CTRL     = 8'h00;
   localparam logic [7:0]  ADR_TARGET   = 8'h04;
   localparam logic [7:0]  ADR_UPPER    = 8'h08;
   localparam logic [7:0]  ADR_LOWER    = 8'h0C;
   localparam logic [7:0]  ADR_RISE     = 8'h10;
   localparam logic [7:0]  ADR_FALL     = 8'h14;
   localparam logic [7:0]  ADR_MSP_SEL  = 8'h18;
   localparam logic [7:0]  ADR_STATUS   = 8'h1C;
   localparam logic [7:0]  ADR_WORK     = 8'h20;
   localparam logic [7:0]  ADR_BANK     = 8'h40;
   // control register fields
   localparam int          CTRL_RUN     = 0;
   localparam int          CTRL_ST      = 1;
   localparam int          CTRL_ALM     = 2;
   localparam int          CTRL_AT      = 3;
   localparam int          CTRL_LIMRST  = 4;
   localparam int          CTRL_UNIT_LO = 5;
   localparam int          CTRL_UNIT_HI = 6;
   // status register fields
   localparam int          STAT_RAMPING = 0;
   localparam int          STAT_AT_PEND = 1;
   localparam int          STAT_RAMP_EN = 2;
   // reset values and encodings
   localparam logic [15:0] RATE_OFF     = 16'h0000;
   localparam logic [15:0] RATE_SAME    = 16'hFFFF;
   localparam logic [1:0]  UNIT_SEC     = 2'h0;
   localparam logic [1:0]  UNIT_MIN     = 2'h1;
   localparam logic [15:0] UPPER_RST    = 16'h7FFF;
   localparam logic [15:0] LOWER_RST    = 16'h8000;
   localparam logic [15:0] SP_RST       = 16'h0000;

   typedef logic signed [15:0] spc_val_t;

   typedef struct packed {
      logic                                ack;
      logic [31:0]                         rdat;
      logic                                run;
      logic                                run_prev;
      logic                                init;
      logic                                st_en;
      logic                                alm_sel;
      logic                                at_pend;
      logic                                at_start;
      logic [1:0]                          unit;
      spc_val_t                            upper;
      spc_val_t                            lower;
      logic [15:0]                         rise;
      logic [15:0]                         fall;
      logic [MSP_AW-1:0]                   sel;
      logic [MSP_DEPTH-1:0][15:0]          bank;
      spc_val_t                            work;
      spc_val_t                            alarm;
      logic [SEC_CW-1:0]                   sec_cnt;
      logic [UNIT_CW-1:0]                  unit_cnt;
   } spc_state_t;
endpackage : spc_pkg

//--- hw/spc_clamp_ramp.sv
// set point limiter, multi set point bank and rate-limited ramp behind a wishbone slave
// How it works
// - stored set points are always held between the lower and upper bound
// - a bound change that strands a set point moves it back inside
// - limiter reset forces an out-of-range set point to the crossed bound
// - range or scaling change resets both bounds to the input range
// - with ramp on, working set point moves no faster than the rate
// - control output follows the ramped working set point, not the target
// - rise rate, fall rate and a time unit define the ramp
// - after reset rise rate is OFF and fall rate is SAME
// - working set point is readable as a monitor value
// - switching bank entry ramps just like a direct set point change
// - ramp acts only with self-tuning off; self-tuning resets to on
// - only at stop-to-run does the ramp start from the process value; reset leaves the ramp off, so power-up does not
// - a requested auto-tune waits until the ramp has reached the target
// - stopped control or an error disables the ramp
// - alarm reference is the working or target set point per selection
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module spc_clamp_ramp
   import spc_pkg::*;
#(
   parameter int SEC_CYC = SEC_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output      logic [31:0] wb_dat_o,
   output      logic        wb_ack_o,
   input  wire logic [15:0] process_value,
   input  wire logic        error_present,
   input  wire logic [15:0] input_range_hi,
   input  wire logic [15:0] input_range_lo,
   input  wire logic        range_changed,
   output      logic [15:0] control_sp,
   output      logic [15:0] alarm_sp,
   output      logic        at_start
);

   // refuse a time base that the second counter cannot hold
   if (SEC_CYC < 1 || SEC_CYC >= (1 << SEC_CW)) begin : g_bad_sec_cyc
      $error("SEC_CYC out of range");
   end

   spc_state_t q;
   spc_state_t d;

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      if ($signed(v) > $signed(hi)) return hi;
      else if ($signed(v) < $signed(lo)) return lo;
      else return v;
   endfunction : clamp

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] be);
      return {be[1] ? dat[15:8] : old[15:8], be[0] ? dat[7:0] : old[7:0]};
   endfunction : merge16

   logic               req;
   logic               wr;
   logic [15:0]        tgt;
   logic               ramp_ok;
   logic               ramping;
   logic [15:0]        down_rate;
   logic signed [16:0] diff;
   logic               unit_done;
   logic               step;

   assign req       = wb_cyc_i & wb_stb_i;
   assign wr        = req & wb_we_i & q.ack;
   assign tgt       = q.bank[q.sel];
   assign ramp_ok   = (q.rise != RATE_OFF) & ~q.st_en & q.run & ~error_present;
   assign ramping   = ramp_ok & (q.work != tgt);
   assign down_rate = (q.fall == RATE_SAME) ? q.rise : q.fall;
   assign diff      = 17'($signed(tgt)) - 17'($signed(q.work));
   assign unit_done = (q.sec_cnt == SEC_CW'(SEC_CYC - 1));
   assign step      = unit_done & (q.unit_cnt == UNIT_CW'(0));

   always_comb begin
      d = q;
      d.at_start = 1'b0;
      d.run_prev = q.run;
      d.init     = 1'b0;
      // bus slave: ack one cycle after request, write lands on the ack edge
      d.ack  = req & ~q.ack;
      d.rdat = 32'h0000_0000;
      if (req & ~q.ack & ~wb_we_i) begin
         if (wb_adr_i >= ADR_BANK && wb_adr_i < ADR_BANK + 8'(4 * MSP_DEPTH)) begin
            d.rdat[15:0] = q.bank[wb_adr_i[MSP_AW+1:2]];
         end
         else begin
            case (wb_adr_i)
               ADR_CTRL: begin
                  d.rdat[CTRL_RUN] = q.run;
                  d.rdat[CTRL_ST]  = q.st_en;
                  d.rdat[CTRL_ALM] = q.alm_sel;
                  d.rdat[CTRL_AT]  = q.at_pend;
                  d.rdat[CTRL_UNIT_HI:CTRL_UNIT_LO] = q.unit;
               end
               ADR_TARGET:  d.rdat[15:0] = tgt;
               ADR_UPPER:   d.rdat[15:0] = q.upper;
               ADR_LOWER:   d.rdat[15:0] = q.lower;
               ADR_RISE:    d.rdat[15:0] = q.rise;
               ADR_FALL:    d.rdat[15:0] = q.fall;
               ADR_MSP_SEL: d.rdat[MSP_AW-1:0] = q.sel;
               ADR_STATUS: begin
                  d.rdat[STAT_RAMPING] = ramping;
                  d.rdat[STAT_AT_PEND] = q.at_pend;
                  d.rdat[STAT_RAMP_EN] = ramp_ok;
               end
               ADR_WORK:    d.rdat[15:0] = q.work;
               default:     d.rdat = 32'h0000_0000;
            endcase
         end
      end
      if (wr) begin
         if (wb_adr_i >= ADR_BANK && wb_adr_i < ADR_BANK + 8'(4 * MSP_DEPTH)) begin
            d.bank[wb_adr_i[MSP_AW+1:2]] = merge16(q.bank[wb_adr_i[MSP_AW+1:2]], wb_dat_i, wb_sel_i);
         end
         else begin
            case (wb_adr_i)
               ADR_CTRL: begin
                  if (wb_sel_i[0]) begin
                     d.run     = wb_dat_i[CTRL_RUN];
                     d.st_en   = wb_dat_i[CTRL_ST];
                     d.alm_sel = wb_dat_i[CTRL_ALM];
                     d.unit    = wb_dat_i[CTRL_UNIT_HI:CTRL_UNIT_LO];
                     if (wb_dat_i[CTRL_AT]) d.at_pend = 1'b1;
                  end
               end
               ADR_TARGET:  d.bank[q.sel] = merge16(tgt, wb_dat_i, wb_sel_i);
               ADR_UPPER:   d.upper = merge16(q.upper, wb_dat_i, wb_sel_i);
               ADR_LOWER:   d.lower = merge16(q.lower, wb_dat_i, wb_sel_i);
               ADR_RISE:    d.rise = merge16(q.rise, wb_dat_i, wb_sel_i);
               ADR_FALL:    d.fall = merge16(q.fall, wb_dat_i, wb_sel_i);
               ADR_MSP_SEL: if (wb_sel_i[0]) d.sel = wb_dat_i[MSP_AW-1:0];
               default:     d.run = d.run;
            endcase
         end
      end
      // input type, unit or scaling change, or software limiter reset
      if (range_changed | (wr & (wb_adr_i == ADR_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_LIMRST])) begin
         d.upper = input_range_hi;
         d.lower = input_range_lo;
      end
      // every stored set point is pulled to the bound it crossed
      for (int i = 0; i < MSP_DEPTH; i++) begin
         d.bank[i] = clamp(d.bank[i], d.lower, d.upper);
      end
      // ramp time base: one step per selected time unit
      d.sec_cnt = unit_done ? SEC_CW'(0) : q.sec_cnt + SEC_CW'(1);
      if (unit_done) begin
         if (q.unit_cnt != UNIT_CW'(0)) d.unit_cnt = q.unit_cnt - UNIT_CW'(1);
         else if (q.unit == UNIT_SEC) d.unit_cnt = UNIT_CW'(0);
         else if (q.unit == UNIT_MIN) d.unit_cnt = SEC_PER_MIN - UNIT_CW'(1);
         else d.unit_cnt = SEC_PER_HOUR - UNIT_CW'(1);
      end
      // working set point
      if (!ramp_ok) begin
         d.work = tgt;
      end
      else if (q.init | (q.run & ~q.run_prev)) begin
         d.work = process_value;
      end
      else if (step) begin
         if (diff > $signed({1'b0, q.rise})) d.work = q.work + q.rise;
         else if (down_rate != RATE_OFF && diff < -$signed({1'b0, down_rate})) begin
            d.work = q.work - down_rate;
         end
         else d.work = tgt;
      end
      // auto-tune waits for the ramp to finish
      if (q.at_pend & ~ramping) begin
         // a request written in this same cycle stays pending
         d.at_pend  = wr & (wb_adr_i == ADR_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_AT];
         d.at_start = 1'b1;
      end
      d.alarm = q.alm_sel ? tgt : q.work;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q          <= '0;
         q.init     <= 1'b1;
         q.st_en    <= 1'b1;
         q.rise     <= RATE_OFF;
         q.fall     <= RATE_SAME;
         q.upper    <= UPPER_RST;
         q.lower    <= LOWER_RST;
         q.unit     <= UNIT_SEC;
         q.bank     <= {MSP_DEPTH{SP_RST}};
         q.work     <= SP_RST;
         q.alarm    <= SP_RST;
      end
      else begin
         q <= d;
      end
   end

   assign wb_ack_o   = q.ack;
   assign wb_dat_o   = q.rdat;
   assign control_sp = q.work;
   assign alarm_sp   = q.alarm;
   assign at_start   = q.at_start;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_run_rise;
      q.run && !q.run_prev && ramp_ok && !q.init;
   endsequence

   a_sp_in_bounds: assert property ($signed(q.lower) <= $signed(q.upper)
      |-> $signed(tgt) <= $signed(q.upper) && $signed(tgt) >= $signed(q.lower))
      else $error("target set point outside bounds");
   a_upper_reclamp: assert property (wr && wb_adr_i == ADR_UPPER && wb_sel_i[1:0] == 2'b11 && !range_changed
      && $signed(tgt) > $signed(wb_dat_i[15:0]) && $signed(wb_dat_i[15:0]) >= $signed(q.lower)
      |=> tgt == $past(wb_dat_i[15:0]))
      else $error("set point not moved to new upper bound");
   a_lower_crossed: assert property (range_changed && $signed(tgt) < $signed(input_range_lo)
      && $signed(input_range_lo) <= $signed(input_range_hi) |=> tgt == $past(input_range_lo))
      else $error("set point not forced to crossed lower bound");
   a_range_reset: assert property (range_changed |=> q.upper == $past(input_range_hi)
      && q.lower == $past(input_range_lo))
      else $error("bounds not reset to input range");
   a_rise_limited: assert property (ramp_ok && $past(ramp_ok) && !$past(q.init)
      && !$past(q.run && !q.run_prev) && $past(q.rise) == q.rise
      |-> $signed(17'($signed(q.work)) - 17'($signed($past(q.work)))) <= $signed({1'b0, q.rise}))
      else $error("working set point rose faster than rate");
   a_control_work: assert property (ramping && !step && !q.init && !(q.run && !q.run_prev)
      |=> $stable(control_sp))
      else $error("control set point moved between ramp steps");
   a_reset_default: assert property ($past(!rstn) |-> q.rise == RATE_OFF && q.fall == RATE_SAME
      && q.st_en)
      else $error("ramp defaults wrong after reset");
   a_start_from_pv: assert property (s_run_rise |=> q.work == $past(process_value))
      else $error("ramp did not start from process value");
   a_at_after_ramp: assert property (q.at_start |-> $past(!ramping) && $past(q.at_pend))
      else $error("auto-tune started during ramp");
   a_stop_no_ramp: assert property ((!q.run || error_present || q.st_en) |=> q.work == $past(tgt))
      else $error("ramp active while stopped or in error");
   a_alarm_ref: assert property (##1 alarm_sp == ($past(q.alm_sel) ? $past(tgt) : $past(q.work)))
      else $error("alarm reference wrong");

endmodule : spc_clamp_ramp

//--- testbench/spc_plant.sv
// far-side model: measured process value and input range source
`timescale 1ns/10ps
module spc_plant
   import spc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [15:0] pv_cmd,
   input  wire logic        rng_req,
   output      logic [15:0] process_value,
   output      logic [15:0] input_range_hi,
   output      logic [15:0] input_range_lo,
   output      logic        range_changed
);
   logic rng_q;
   // input range of the selected sensor, -200 to 1300
   assign input_range_hi = 16'h0514;
   assign input_range_lo = 16'hFF38;
   // a range change request gives one pulse
   always_ff @(posedge core_clk) begin
      rng_q         <= rstn & rng_req;
      range_changed <= rstn & rng_req & ~rng_q;
      process_value <= pv_cmd;
   end
endmodule : spc_plant

//--- testbench/spc_clamp_ramp_test.sv
// self-checking bench for the set point clamp and ramp block
`timescale 1ns/10ps
module spc_clamp_ramp_test;
   import spc_pkg::*;
   logic        core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, error_present;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] process_value, input_range_hi, input_range_lo, pv_cmd;
   logic        range_changed, rng_req, at_start, mon_on;
   logic [15:0] control_sp, alarm_sp, prev_sp;
   logic [31:0] exp_q[$];
   int          n_mismatch, check_count, seed, at_cnt, gap, i;
   spc_val_t    v, e, dlt;

   spc_clamp_ramp #(.SEC_CYC(10)) u_spc_clamp_ramp (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .process_value(process_value), .error_present(error_present),
      .input_range_hi(input_range_hi), .input_range_lo(input_range_lo), .range_changed(range_changed),
      .control_sp(control_sp), .alarm_sp(alarm_sp), .at_start(at_start));
   spc_plant u_spc_plant (.core_clk(core_clk), .rstn(rstn), .pv_cmd(pv_cmd), .rng_req(rng_req),
      .process_value(process_value), .input_range_hi(input_range_hi), .input_range_lo(input_range_lo),
      .range_changed(range_changed));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // one classic cycle; caller stands just after a rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= (a == ADR_CTRL || a == ADR_MSP_SEL) ? 4'h1 : 4'h3;
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 50) n_mismatch++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(a, 1'b1, {16'h0000, d});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      exp_q.push_back(ex);
      bus(a, 1'b0, 32'h0000_0000);
   endtask : rd

   // read results are compared against the oldest note
   always @(posedge core_clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
         chk("read data", exp_q.pop_front(), wb_dat_o);
   end

   // ramp steps: at most the rise rate, one step per time unit
   always @(posedge core_clk) begin
      if (at_start === 1'b1) begin
         at_cnt++;
         chk("sp at tune start", 32'h0000_0082, {16'h0000, control_sp});
      end
      gap++;
      if (mon_on && control_sp !== prev_sp) begin
         dlt = $signed(control_sp) - $signed(prev_sp);
         chk("step within rate", 1, (dlt <= 5 && dlt >= -5));
         chk("one step per unit", 1, gap >= 10);
         gap = 0;
      end
      prev_sp = control_sp;
   end

   initial begin
      #(100 * 20000);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {error_present, rng_req, mon_on, pv_cmd} = '0;
      {n_mismatch, check_count, at_cnt, gap} = '0;
      seed = 2;
      rstn = 1'b0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      rd(ADR_RISE, 32'h0000_0000);
      rd(ADR_FALL, 32'h0000_FFFF);
      rd(ADR_CTRL, 32'h0000_0002);
      rd(8'h30, 32'h0000_0000);
      wr(ADR_TARGET, 16'hFC18);
      rng_req <= 1'b1;
      repeat (3) @(posedge core_clk);
      rng_req <= 1'b0;
      rd(ADR_UPPER, 32'h0000_0514);
      rd(ADR_LOWER, 32'h0000_FF38);
      rd(ADR_TARGET, 32'h0000_FF38);
      wr(ADR_UPPER, 16'h03E8);
      wr(ADR_LOWER, 16'hFF9C);
      for (i = 0; i < 4; i++) begin
         v = 16'($random(seed));
         e = (v > 1000) ? 16'sd1000 : (v < -100) ? -16'sd100 : v;
         wr(ADR_TARGET, v);
         rd(ADR_TARGET, {16'h0000, e});
      end
      wr(ADR_TARGET, 16'h01F4);
      wr(ADR_UPPER, 16'h012C);
      rd(ADR_TARGET, 32'h0000_012C);
      wr(ADR_UPPER, 16'h03E8);
      wr(ADR_TARGET, 16'h0082);
      pv_cmd <= 16'h0064;
      wr(ADR_RISE, 16'h0005);
      wr(ADR_CTRL, 16'h0001);
      repeat (2) @(posedge core_clk);
      chk("ramp start from pv", 1, control_sp >= 16'h0064 && control_sp <= 16'h0069);
      gap = 10;
      mon_on = 1'b1;
      rd(ADR_STATUS, 32'h0000_0005);
      wr(ADR_CTRL, 16'h0009);
      chk("loop sp is ramped", 1, control_sp < 16'h0082);
      i = 0;
      while (control_sp !== 16'h0082 && i < 1000) begin
         @(posedge core_clk);
         i++;
      end
      repeat (5) @(posedge core_clk);
      chk("tune starts once", 1, at_cnt);
      rd(ADR_WORK, 32'h0000_0082);
      wr(ADR_BANK + 8'h04, 16'h0064);
      wr(ADR_CTRL, 16'h0005);
      wr(ADR_MSP_SEL, 16'h0001);
      repeat (3) @(posedge core_clk);
      chk("alarm on target", 32'h0000_0064, {16'h0000, alarm_sp});
      chk("bank change ramps down", 1, control_sp > 16'h0064);
      mon_on = 1'b0;
      error_present <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("error drops ramp", 32'h0000_0064, {16'h0000, control_sp});
      rd(ADR_STATUS, 32'h0000_0000);
      error_present <= 1'b0;
      repeat (3) @(posedge core_clk);
      // explicit fall rate with a minute time unit
      wr(ADR_FALL, 16'h0002);
      wr(ADR_CTRL, 16'h0021);
      wr(ADR_TARGET, 16'h005A);
      i = 0;
      while (control_sp === 16'h0064 && i < 700) begin
         @(posedge core_clk);
         i++;
      end
      chk("first fall step", 32'h0000_0062, {16'h0000, control_sp});
      i = 0;
      while (control_sp === 16'h0062 && i < 700) begin
         @(posedge core_clk);
         i++;
      end
      chk("minute unit period", 32'd600, i);
      chk("second fall step", 32'h0000_0060, {16'h0000, control_sp});
      // software limiter reset while stopped
      wr(ADR_CTRL, 16'h0010);
      rd(ADR_UPPER, 32'h0000_0514);
      rd(ADR_LOWER, 32'h0000_FF38);
      chk("stop drops ramp", 32'h0000_005A, {16'h0000, control_sp});
      tally_and_finish();
   end
endmodule : spc_clamp_ramp_test
